// >>> verilog/t1z_framer_coder.sv
/*
  T1 line coding: T1DM framing and channel 24, bit-7 and eight-zero
  substitution, AMI with alarm responses, and the receive decoder.
  Assumes bit strobes from the line interface, synchronous to sys_clk;
  the caller supplies data aligned to the internal frame position.
*/
`timescale 1ns/10ps
module t1z_framer_coder
  import t1z_pkg::*;
#(
  parameter bit LATE_VARIANT = 1'b1          // Decoder always on
)
(
  input  wire logic     sys_clk,                // System clock, 40 MHz
  input  wire logic     rst,                    // Sync reset, high
  input  wire logic     tx_strobe,              // One bit time
  input  wire logic     tx_data,                // Payload or F bit
  input  wire logic     t1dm_mode,              // T1DM framing
  input  wire logic     b7_enable,              // Bit-7 substitution
  input  wire logic     tx_subst_encode_enable, // Eight-zero encoder
  input  wire logic     tx_dlink_bit,           // Auxiliary link bit
  input  wire logic     red_alarm,              // Local loss of align
  input  wire logic     blue_alarm_req,         // Send all ones
  output t1z_ami_s      tx_line_r,              // Transmit rails
  output logic          yellow_sent_r,          // Yellow being sent
  input  wire logic     rx_strobe,              // One received symbol
  input  wire t1z_ami_s rx_line,                // Received rails
  input  wire logic     status_report_select,   // 0 reports codes
  output logic          rx_data_r,              // Decoded bit
  output logic          rx_valid_r,             // Decoded bit strobe
  output logic          bpv_event_r,            // Violation to count
  output logic          subst_code_seen_flag_r  // Code detected
);

  logic [BIT_POS_W-1:0] pos_r, pos_nxt;
  logic [FRAME_W-1:0]   frame_r, frame_nxt;
  logic [7:0]           dl_r, dl_nxt, mark_r, mark_nxt, vio_r, vio_nxt;
  logic                 last_r, last_nxt, pol, pulse, f_exp, chan_end;
  logic                 yel_nxt;
  t1z_ami_s             line_nxt;
  t1z_txsrc_e           src;

  function automatic logic t1dm_fbit(input logic [FRAME_W-1:0] fr);
    t1dm_fbit = fr[0] ? SIG_PAT[fr[3:1]] : TERM_PAT[fr[3:1]];
  endfunction

  // ---------------------------------------------------------------
  // Frame position
  // ---------------------------------------------------------------
  always_comb
  begin
    pos_nxt   = pos_r;
    frame_nxt = frame_r;
    if (tx_strobe)
    begin
      if (pos_r == POS_LAST)
      begin
        pos_nxt   = POS_F_BIT;
        frame_nxt = (frame_r == FRAME_LAST) ? 4'h0 : frame_r + 4'h1;
      end
      else
        pos_nxt = pos_r + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Channel stage: one channel delay so a byte can be rewritten
  // ---------------------------------------------------------------
  assign chan_end = (pos_r != POS_F_BIT) && (pos_r[2:0] == CH_LOW_POS);
  assign f_exp    = t1dm_fbit(frame_r);

  always_comb
  begin
    dl_nxt  = dl_r;
    yel_nxt = t1dm_mode & red_alarm;
    if (tx_strobe)
    begin
      dl_nxt = {dl_r[6:0], tx_data};
      if (pos_r == POS_F_BIT && t1dm_mode)
        dl_nxt[0] = f_exp;
      if (chan_end)
      begin
        if (t1dm_mode && pos_r == POS_LAST)
        begin
          dl_nxt             = CH24_SYNC;
          dl_nxt[CH24_YEL]   = ~red_alarm;
          dl_nxt[CH24_DLINK] = tx_dlink_bit;
        end
        // In T1DM user bit 8 passes as given by the network
        // Host keeps substitution off in T1DM; not enforced
        else if (b7_enable && dl_nxt == ZERO_BYTE)
          dl_nxt = B7_FORCE;
      end
    end
  end

  // ---------------------------------------------------------------
  // Eight-zero substitution and AMI
  // ---------------------------------------------------------------
  // The window is blind to channel edges, so runs span channels.
  always_comb
  begin
    mark_nxt = mark_r;
    vio_nxt  = vio_r;
    last_nxt = last_r;
    line_nxt = tx_line_r;
    pol      = ~last_r;
    pulse    = 1'b0;
    src      = blue_alarm_req ? TXS_BLUE : TXS_DATA;
    if (tx_strobe)
    begin
      mark_nxt = {mark_r[6:0], dl_r[7]};
      vio_nxt  = {vio_r[6:0], 1'b0};
      if (tx_subst_encode_enable && mark_nxt == ZERO_BYTE)
      begin
        mark_nxt = B8_MARK;
        vio_nxt  = B8_VIO;
      end
      case (src)
        TXS_BLUE:
        begin
          pulse = 1'b1;
          pol   = ~last_r;
        end
        TXS_DATA:
        begin
          pulse = mark_r[7];
          pol   = vio_r[7] ? last_r : ~last_r;
        end
        default:
        begin
          pulse = 1'b0;
          pol   = ~last_r;
        end
      endcase
      if (pulse)
        last_nxt = pol;
      line_nxt.pos = pulse & pol;
      line_nxt.neg = pulse & ~pol;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pos_r         <= 8'h00;
      frame_r       <= 4'h0;
      dl_r          <= 8'h00;
      mark_r        <= 8'h00;
      vio_r         <= 8'h00;
      last_r        <= 1'b0;
      tx_line_r     <= '0;
      yellow_sent_r <= 1'b0;
    end
    else
    begin
      pos_r         <= pos_nxt;
      frame_r       <= frame_nxt;
      dl_r          <= dl_nxt;
      mark_r        <= mark_nxt;
      vio_r         <= vio_nxt;
      last_r        <= last_nxt;
      tx_line_r     <= line_nxt;
      yellow_sent_r <= yel_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Receive path
  // ---------------------------------------------------------------
  // Earlier variant ties decoding to the encoder enable.
  t1z_rx_decode u_rx (
    .sys_clk                (sys_clk),
    .rst                    (rst),
    .rx_strobe              (rx_strobe),
    .rx_line                (rx_line),
    .decode_en              (LATE_VARIANT | tx_subst_encode_enable),
    .status_report_select   (status_report_select),
    .rx_data_r              (rx_data_r),
    .rx_valid_r             (rx_valid_r),
    .bpv_event_r            (bpv_event_r),
    .subst_code_seen_flag_r (subst_code_seen_flag_r)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence ch24_load_s;
    tx_strobe && t1dm_mode && pos_r == POS_LAST;
  endsequence

  t1dm_sync_a: assert property (ch24_load_s |=>
    (dl_r & CH24_MASK) == CH24_SYNC)
    else $error("channel 24 sync pattern wrong");
  t1dm_yellow_a: assert property (ch24_load_s |=>
    dl_r[CH24_YEL] == !$past(red_alarm))
    else $error("channel 24 alarm bit wrong");
  t1dm_dlink_a: assert property (ch24_load_s |=>
    dl_r[CH24_DLINK] == $past(tx_dlink_bit))
    else $error("channel 24 data link bit wrong");
  t1dm_fbit_a: assert property (tx_strobe && t1dm_mode
    && pos_r == POS_F_BIT |=> dl_r[0] == $past(f_exp))
    else $error("framing bit pattern wrong");
  b7_force_a: assert property (tx_strobe && b7_enable && chan_end
    && !t1dm_mode && {dl_r[6:0], tx_data} == ZERO_BYTE
    |=> dl_r == B7_FORCE)
    else $error("all-zero channel not forced");
  b8_insert_a: assert property (tx_strobe && tx_subst_encode_enable
    && {mark_r[6:0], dl_r[7]} == ZERO_BYTE
    |=> mark_r == B8_MARK ##0 vio_r == B8_VIO)
    else $error("zero run not substituted");
  b8_violation_a: assert property (tx_strobe && !blue_alarm_req
    && mark_r[7] && vio_r[7] |=> tx_line_r.pos == $past(last_r)
    && tx_line_r.neg != $past(last_r))
    else $error("violation polarity wrong");
  ami_alternate_a: assert property (tx_strobe && !blue_alarm_req
    && mark_r[7] && !vio_r[7] |=> tx_line_r.pos != $past(last_r))
    else $error("mark polarity did not alternate");
  blue_ones_a: assert property (tx_strobe && blue_alarm_req
    |=> tx_line_r.pos != tx_line_r.neg)
    else $error("blue alarm bit not a mark");
  yellow_out_a: assert property (t1dm_mode && red_alarm
    |=> yellow_sent_r)
    else $error("yellow not indicated");

endmodule // t1z_framer_coder

// >>> verilog/t1z_pkg.sv
/*
  Constants and types shared by the T1 line coding block: frame geometry,
  the T1DM framing and channel 24 patterns, and the substitution codes.
  Assumes one system clock and bit strobes from the line side.
*/
package t1z_pkg;

  // ---------------------------------------------------------------
  // Frame geometry
  // ---------------------------------------------------------------
  localparam int              BIT_POS_W  = 8;
  localparam int              FRAME_W    = 4;
  localparam logic [7:0]      POS_F_BIT  = 8'h00;
  localparam logic [7:0]      POS_LAST   = 8'hc0;  // 193 bit times
  localparam logic [3:0]      FRAME_LAST = 4'hb;   // 12 frames
  localparam logic [2:0]      CH_LOW_POS = 3'h0;

  // ---------------------------------------------------------------
  // T1DM patterns; bit j of a pattern is odd/even frame pair j
  // ---------------------------------------------------------------
  localparam logic [5:0]      TERM_PAT   = 6'h15;  // 1,0,1,0,1,0
  localparam logic [5:0]      SIG_PAT    = 6'h1c;  // 0,0,1,1,1,0
  localparam logic [7:0]      CH24_SYNC  = 8'hb8;  // first bit at [7]
  localparam logic [7:0]      CH24_MASK  = 8'hf9;
  localparam int              CH24_YEL   = 2;      // byte bit 6
  localparam int              CH24_DLINK = 1;      // byte bit 7

  // ---------------------------------------------------------------
  // Zero substitution
  // ---------------------------------------------------------------
  localparam logic [7:0]      ZERO_BYTE  = 8'h00;
  localparam logic [7:0]      B7_FORCE   = 8'h02;  // seventh bit
  localparam logic [7:0]      B8_MARK    = 8'h1b;  // 000VB0VB
  localparam logic [7:0]      B8_VIO     = 8'h12;  // V at 4th and 7th

  typedef struct packed {
    logic pos;
    logic neg;
  } t1z_ami_s;

  typedef enum logic {
    TXS_DATA,
    TXS_BLUE
  } t1z_txsrc_e;

endpackage

// >>> verilog/t1z_rx_decode.sv
/*
  Receive side eight-zero substitution monitor and decoder.
  Assumes rx_line is already split into bipolar rails, one symbol
  per rx_strobe, synchronous to sys_clk.
*/
`timescale 1ns/10ps
module t1z_rx_decode
  import t1z_pkg::*;
(
  input  wire logic     sys_clk,              // System clock
  input  wire logic     rst,                  // Sync reset, high
  input  wire logic     rx_strobe,            // One symbol this cycle
  input  wire t1z_ami_s rx_line,              // Received rails
  input  wire logic     decode_en,            // Replace codes by zeros
  input  wire logic     status_report_select, // 0 reports detections
  output logic          rx_data_r,            // Decoded bit
  output logic          rx_valid_r,           // Bit strobe
  output logic          bpv_event_r,          // Counted violation
  output logic          subst_code_seen_flag_r // Code detected
);

  logic [7:0] pos_r, neg_r, code_r, pos_nxt, neg_nxt, code_nxt;
  logic       last_r, last_nxt, data_nxt, bpv_nxt, seen_nxt, det;
  logic       lp;

  // ---------------------------------------------------------------
  // Eight symbol window
  // ---------------------------------------------------------------
  always_comb
  begin
    pos_nxt  = pos_r;
    neg_nxt  = neg_r;
    code_nxt = code_r;
    last_nxt = last_r;
    data_nxt = rx_data_r;
    bpv_nxt  = 1'b0;
    seen_nxt = 1'b0;
    det      = 1'b0;
    lp       = last_r;
    if (rx_strobe)
    begin
      pos_nxt  = {pos_r[6:0], rx_line.pos};
      neg_nxt  = {neg_r[6:0], rx_line.neg};
      code_nxt = {code_r[6:0], 1'b0};
      data_nxt = pos_r[7] | neg_r[7];
      // Code marks do not count as violations
      bpv_nxt  = (pos_r[7] | neg_r[7]) & ~code_r[7]
                 & (pos_r[7] == last_r);
      if (pos_r[7] | neg_r[7])
        lp = pos_r[7];
      last_nxt = lp;
      // Watched whether or not decoding is on
      det = ((pos_nxt | neg_nxt) == B8_MARK) && (code_nxt == ZERO_BYTE)
            && (pos_nxt[4] == lp) && (pos_nxt[3] != pos_nxt[4])
            && (pos_nxt[1] == pos_nxt[3]) && (pos_nxt[0] != pos_nxt[1]);
      if (det)
      begin
        code_nxt = B8_MARK;
        seen_nxt = ~status_report_select;
        // Last pulse of the code matches lp, so tracking is kept
        if (decode_en)
        begin
          pos_nxt = ZERO_BYTE;
          neg_nxt = ZERO_BYTE;
        end
      end
    end
  end

  // Bit-7 forced ones are not undone; they pass as received
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pos_r                  <= 8'h00;
      neg_r                  <= 8'h00;
      code_r                 <= 8'h00;
      last_r                 <= 1'b0;
      rx_data_r              <= 1'b0;
      rx_valid_r             <= 1'b0;
      bpv_event_r            <= 1'b0;
      subst_code_seen_flag_r <= 1'b0;
    end
    else
    begin
      pos_r                  <= pos_nxt;
      neg_r                  <= neg_nxt;
      code_r                 <= code_nxt;
      last_r                 <= last_nxt;
      rx_data_r              <= data_nxt;
      rx_valid_r             <= rx_strobe;
      bpv_event_r            <= bpv_nxt;
      subst_code_seen_flag_r <= seen_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  rx_zero_decode_a: assert property (det && decode_en |=>
    ((pos_r | neg_r) & B8_MARK) == ZERO_BYTE)
    else $error("substitution code not replaced by zeros");
  rx_code_flag_a: assert property (det |=>
    subst_code_seen_flag_r == !$past(status_report_select))
    else $error("substitution detection not reported");
  rx_bpv_skip_a: assert property (rx_strobe && code_r[7] |=>
    !bpv_event_r)
    else $error("code violation counted as error");

endmodule // t1z_rx_decode

// >>> verif/t1z_liu_model.sv
/*
  Line interface model: one bit strobe shared by both directions and
  the received rails. Assumes the bench sets sym for the next strobe.
*/
`timescale 1ns/10ps
module t1z_liu_model
  import t1z_pkg::*;
(
  input  wire logic       sys_clk, // System clock
  input  wire logic       run,     // Let strobes run
  input  wire logic [1:0] gap,     // Idle cycles between strobes
  input  wire t1z_ami_s   sym,     // Symbol for the next strobe
  output logic            strobe,  // Bit time, both directions
  output t1z_ami_s        rx_line  // Received rails
);
  logic [1:0] cnt;
  t1z_ami_s   last;

  initial
  begin
    strobe = 1'b0;
    cnt    = 2'h0;
    last   = '0;
  end

  always @(negedge sys_clk)
  begin
    strobe <= run && cnt == 2'h0;
    cnt    <= (!run || cnt == 2'h0) ? gap : cnt - 2'h1;
  end

  always @(posedge sys_clk)
    if (strobe)
      last <= sym;

  // Off the strobe the rails show the inverse, never a stale symbol
  assign rx_line = strobe ? sym : t1z_ami_s'(~last);
endmodule // t1z_liu_model

// >>> verif/tb_t1_zero_sub_and_t1dm_framing.sv
/*
  Self-checking bench for the T1 line coder against a bit-level model.
  Assumes the line interface model gives strobes and received rails.
*/
`timescale 1ns/10ps
module tb_t1_zero_sub_and_t1dm_framing
  import t1z_pkg::*;
;
  localparam int NMAX = 2600;

  logic        sys_clk, rst, tx_data, t1dm_mode, b7_enable, enc_en;
  logic        dlink, red, blue, sel, run, strobe, took;
  logic        yel, rxd, rxv, bpv, seen;
  logic [1:0]  gap;
  logic [31:0] seed;
  t1z_ami_s    sym, rx_line, tx_line;
  int          fails, checks, idx;
  int          inb[NMAX], cb[NMAX], ts[NMAX], rs[NMAX];
  int          rd[NMAX], rb[NMAX], rq[NMAX], dl[14];

  t1z_framer_coder #(.LATE_VARIANT(1'b1)) uut
  (
    .sys_clk(sys_clk), .rst(rst), .tx_strobe(strobe), .tx_data(tx_data),
    .t1dm_mode(t1dm_mode), .b7_enable(b7_enable),
    .tx_subst_encode_enable(enc_en), .tx_dlink_bit(dlink),
    .red_alarm(red), .blue_alarm_req(blue), .tx_line_r(tx_line),
    .yellow_sent_r(yel), .rx_strobe(strobe), .rx_line(rx_line),
    .status_report_select(sel), .rx_data_r(rxd), .rx_valid_r(rxv),
    .bpv_event_r(bpv), .subst_code_seen_flag_r(seen)
  );

  t1z_liu_model liu
  (
    .sys_clk(sys_clk), .run(run), .gap(gap), .sym(sym),
    .strobe(strobe), .rx_line(rx_line)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    took <= strobe && !rst;

  // ----------------------------------------------------------------
  // Model
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Symbol k of a substitution code after a pulse of polarity lp
  function automatic int cs(int k, int lp);
    return (k == 3 || k == 7) ? lp : (k == 4 || k == 6) ? 3 - lp : 0;
  endfunction

  function automatic t1z_ami_s sv(int s);
    return t1z_ami_s'({s == 1, s == 2});
  endfunction

  task automatic prep();
    int p;
    bit z;
    for (int j = 0; j < 14; j++)
      dl[j] = xs() % 2;
    for (int i = 0; i < NMAX; i++)
    begin
      p = i % 193;
      inb[i] = i == 0 || xs() % 16 > 11;
      cb[i] = inb[i];
      if (t1dm_mode && p == 0)
        cb[i] = (i / 193) % 2 == 0 ? (i / 386 + 1) % 2
              : int'((i / 193) % 12 inside {5, 7, 9});
      if (t1dm_mode && p > 184)
        cb[i] = p == 190 ? int'(!red) : p == 191 ? dl[i / 193]
              : int'(8'hb8 >> (192 - p)) % 2;
      z = b7_enable && p % 8 == 0 && p > 0 && !(t1dm_mode && p == 192);
      for (int k = 0; k < 8 && z; k++)
        z = cb[i - k] == 0;
      if (z)
        cb[i - 1] = 1;
    end
  endtask

  task automatic code_line(input logic e);
    int lp;
    int i;
    bit z;
    lp = 2;
    i = 0;
    while (i < NMAX)
    begin
      z = e && i + 8 <= NMAX;
      for (int k = 0; k < 8 && z; k++)
        z = cb[i + k] == 0;
      if (z)
      begin
        for (int k = 0; k < 8; k++)
          ts[i + k] = cs(k, lp);
        i += 8;
      end
      else
      begin
        ts[i] = cb[i] != 0 ? 3 - lp : 0;
        lp = cb[i] != 0 ? 3 - lp : lp;
        i++;
      end
    end
  endtask

  task automatic rx_model();
    int lp;
    int i;
    bit z;
    lp = 2;
    i = 0;
    while (i < NMAX)
    begin
      z = i + 8 <= NMAX;
      for (int k = 0; k < 8 && z; k++)
        z = rs[i + k] == cs(k, lp);
      if (z)
      begin
        for (int k = 0; k < 8; k++)
        begin
          rd[i + k] = 0;
          rb[i + k] = 0;
          rq[i + k] = int'(k == 7);
        end
        i += 8;
      end
      else
      begin
        rd[i] = rs[i] != 0;
        rb[i] = rs[i] != 0 && rs[i] == lp;
        rq[i] = 0;
        lp = rs[i] != 0 ? rs[i] : lp;
        i++;
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Checking and runs
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [1:0] got,
                       input logic [1:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic run_test(input string name, input int n, input int flip);
    // Let the new settings land before the model reads them
    @(negedge sys_clk);
    prep();
    code_line(1'b1);
    rs = ts;
    // Far end always encodes; one mark turned round gives a true error
    for (int i = 100; flip != 0 && i < NMAX; i++)
      if (rs[i] != 0)
      begin
        rs[i] = 3 - rs[i];
        flip = 0;
      end
    code_line(enc_en);
    rx_model();
    rst <= 1'b1;
    repeat (4) @(negedge sys_clk);
    rst <= 1'b0;
    idx = 0;
    @(negedge sys_clk);
    run <= 1'b1;
    while (idx < n)
    begin
      tx_data <= inb[idx][0];
      dlink <= dl[idx / 193][0];
      sym <= sv(rs[idx]);
      @(negedge sys_clk);
      if (took)
      begin
        if (idx >= 16)
          if (blue)
            check("tx mark", {1'b0, ^tx_line}, 2'h1);
          else
            check("tx line", tx_line, sv(ts[idx - 16]));
        check("rx valid", {1'b0, rxv}, 2'h1);
        if (idx >= 8)
        begin
          check("rx data", {1'b0, rxd}, 2'(rd[idx - 8]));
          check("bpv", {1'b0, bpv}, 2'(rb[idx - 8]));
        end
        check("seen", {1'b0, seen}, {1'b0, rq[idx] != 0 && !sel});
        idx++;
      end
      else
        check("idle pulses", {rxv | bpv, seen}, 2'h0);
      check("yellow", {1'b0, yel}, {1'b0, t1dm_mode & red});
    end
    run <= 1'b0;
    $display("test %s done", name);
  endtask

  initial
  begin
    {rst, run, tx_data, dlink, sym} = 6'h20;
    {t1dm_mode, b7_enable, enc_en, red, blue, sel, gap} = 8'h00;
    seed = 32'hf0c8;
    fails = 0;
    checks = 0;
    for (int c = 0; c < 2; c++)
    begin
      {t1dm_mode, b7_enable, enc_en, red, blue, sel, gap} <=
        {5'b00100, c[0], 2'(2 * c)};
      run_test("eight zero", 600, 0);
    end
    {t1dm_mode, b7_enable, enc_en, red, blue, sel, gap} <= 8'h46;
    run_test("bit seven", 600, 1);
    for (int c = 0; c < 2; c++)
    begin
      // Substitution left off in T1DM, as the host must
      {t1dm_mode, b7_enable, enc_en, red, blue, sel, gap} <=
        {3'b100, c[0], 4'b0000};
      run_test("t1dm", 2346, 0);
    end
    {t1dm_mode, b7_enable, enc_en, red, blue, sel, gap} <= 8'h08;
    run_test("blue", 60, 0);
    report_and_stop();
  end

  initial
  begin
    #(20000 * 25);
    fails++;
    $display("unexpected watchdog: expected done seen running");
    report_and_stop();
  end
endmodule // tb_t1_zero_sub_and_t1dm_framing
